// ### logic/vit_top.sv
// Vectored interrupt controller with timer taps, GPIO edges, stack push and APB registers.
// Behaviour
// [RULE1] Seven sources, each maskable: bus reset, two taps, two endpoints, wake, GPIO.
// [RULE2] A 12-bit counter steps once per microsecond and wraps freely.
// [RULE3] Taps request every 128 us and 1.024 ms, only while enabled.
// [RULE4] Firmware reads the counter at any time without disturbing it.
// [RULE5] Endpoint requests rise only after a transaction completes on the bus.
// [RULE6] A per-pin mask over ten GPIO inputs gates the shared GPIO request.
// [RULE7] Each GPIO pin selects rising or falling edge as its trigger.
// [RULE8] Acknowledge disables interrupts and pushes PC and flags as two bytes.
// [RULE9] Requests stay pending until taken; fixed priority picks the vector.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`include "vit_defines.svh"

module vit_top
  import vit_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int GPIO_N = 10,
  parameter int CNT_W = 12
)
(
  input wire logic core_clk, // System clock, 100 MHz.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable, freezes all state when low.
  input wire logic [ADDR_W-1:0] paddr, // APB address.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped address.
  input wire logic usb_bus_reset, // Pulse: USB bus reset seen.
  input wire logic ep0_done, // Pulse: endpoint 0 transaction completed.
  input wire logic ep1_done, // Pulse: endpoint 1 transaction completed.
  input wire logic wake_evt, // Pulse: wake-up timer expired.
  input wire logic [GPIO_N-1:0] gpio_in, // GPIO pin levels.
  input wire logic irq_ack, // Core takes the offered vector.
  input wire logic reti, // Core executes return from interrupt.
  input wire logic [13:0] ret_pc, // Return program counter at acknowledge.
  input wire logic [1:0] ret_flags, // Carry and zero flags at acknowledge.
  output logic irq_req, // Interrupt request to the core.
  output vit_vec_t irq_vec, // Vector number of the request.
  output logic gie, // Global interrupt enable.
  output logic stk_we, // Stack byte write strobe.
  output logic [7:0] stk_addr, // Stack byte address.
  output logic [7:0] stk_wdata, // Stack byte data.
  output logic [7:0] psp // Program stack pointer.
);
  localparam int TICK_CYC = `VIT_TICK_NS / `VIT_CLK_NS;

  vit_state_e state;
  vit_state_e next_state;
  vit_src_t en;
  vit_src_t pend;
  vit_src_t next_pend;
  vit_src_t src_evt;
  vit_src_t act;
  vit_src_t clr;
  vit_vec_t top_idx;
  logic [GPIO_N-1:0] gmask;
  logic [GPIO_N-1:0] gpol;
  logic [CNT_W-1:0] count;
  logic [7:0] hi_hold;
  logic [7:0] next_psp;
  logic [31:0] rd_val;
  logic tap_fast;
  logic tap_slow;
  logic gpio_evt;
  logic take;
  logic reti_take;
  logic push_step;
  logic next_gie;
  logic acc;
  logic wr_en;
  logic rd_hit;
  logic hit_en;
  logic hit_pend;
  logic hit_timer;
  logic hit_gmask;
  logic hit_gpol;
  logic hit_psp;
  logic hit_stat;

  // Timer and GPIO edge logic.
  vit_timer #(.CNT_W(CNT_W), .TICK_CYC(TICK_CYC), .FAST_US(`VIT_FAST_US),
    .SLOW_US(`VIT_SLOW_US)) vit_timer_i (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .count(count),
    .tap_fast(tap_fast),
    .tap_slow(tap_slow)
  );

  vit_gpio_irq #(.GPIO_N(GPIO_N)) vit_gpio_irq_i (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .gpio_in(gpio_in),
    .mask(gmask),
    .pol(gpol),
    .evt(gpio_evt)
  );

  // Source events in priority order, bit zero highest.
  assign src_evt[`VIT_SRC_BUSRST] = usb_bus_reset; // [RULE1]
  assign src_evt[`VIT_SRC_FAST] = tap_fast; // [RULE3]
  assign src_evt[`VIT_SRC_SLOW] = tap_slow; // [RULE3]
  assign src_evt[`VIT_SRC_EP0] = ep0_done; // [RULE5]
  assign src_evt[`VIT_SRC_EP1] = ep1_done; // [RULE5]
  assign src_evt[`VIT_SRC_WAKE] = wake_evt; // [RULE1]
  assign src_evt[`VIT_SRC_GPIO] = gpio_evt; // [RULE6]

  // Pending latch: a new event wins over the clear of the same cycle.
  assign act = pend & en; // [RULE1]
  assign clr = take ? vit_src_t'(7'h01 << irq_vec) : '0; // [RULE9]
  assign next_pend = (pend & ~clr) | (src_evt & en); // [RULE9] [RULE3]

  // Lowest numbered active source wins.
  always_comb
  begin
    top_idx = '0;
    for (int i = VIT_NSRC - 1; i >= 0; i--)
    begin
      if (act[i])
      begin
        top_idx = vit_vec_t'(i); // [RULE9]
      end
    end
  end

  // Acknowledge, return and stack push steps.
  assign take = ce && irq_ack && irq_req && (state == VIT_IDLE); // [RULE8]
  assign reti_take = ce && reti && (state == VIT_IDLE) && !take; // [RULE8]
  assign push_step = take || (ce && (state == VIT_PUSH_LO)); // [RULE8]

  // APB decode; one wait state before pready.
  assign acc = psel && penable && !pready;
  assign wr_en = ce && psel && penable && pready && pwrite && !pslverr;
  assign hit_en = (paddr == `VIT_ADDR_EN);
  assign hit_pend = (paddr == `VIT_ADDR_PEND);
  assign hit_timer = (paddr == `VIT_ADDR_TIMER);
  assign hit_gmask = (paddr == `VIT_ADDR_GMASK);
  assign hit_gpol = (paddr == `VIT_ADDR_GPOL);
  assign hit_psp = (paddr == `VIT_ADDR_PSP);
  assign hit_stat = (paddr == `VIT_ADDR_STAT);
  assign rd_hit = hit_en || hit_pend || hit_timer || hit_gmask || hit_gpol || hit_psp
    || hit_stat;

  // Read data selection.
  assign rd_val = hit_en ? {23'h000000, gie, 1'b0, en}
    : hit_pend ? {25'h0000000, pend}
    : hit_timer ? {{(32 - CNT_W){1'b0}}, count} // [RULE4]
    : hit_gmask ? {{(32 - GPIO_N){1'b0}}, gmask}
    : hit_gpol ? {{(32 - GPIO_N){1'b0}}, gpol}
    : hit_psp ? {24'h000000, psp}
    : hit_stat ? {26'h0000000, state != VIT_IDLE, irq_req, 1'b0, irq_vec}
    : 32'h00000000;

  // Global enable: acknowledge clears, return or software sets.
  assign next_gie = take ? 1'b0 // [RULE8]
    : reti_take ? 1'b1 // [RULE8]
    : (wr_en && hit_en) ? pwdata[`VIT_EN_GIE_BIT]
    : gie;

  // Stack pointer: push steps up, return drops two, software may load it.
  assign next_psp = push_step ? 8'(psp + 8'h01) // [RULE8]
    : reti_take ? 8'(psp - 8'h02) // [RULE8]
    : (wr_en && hit_psp) ? pwdata[7:0]
    : psp;

  // Push sequencer.
  always_comb
  begin
    next_state = state;
    case (state)
      VIT_IDLE: if (take) next_state = VIT_PUSH_LO;
      VIT_PUSH_LO: next_state = VIT_PUSH_HI;
      VIT_PUSH_HI: next_state = VIT_IDLE;
      default: next_state = VIT_IDLE;
    endcase
  end

  // Control state and pending flags.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= VIT_IDLE;
      pend <= '0;
      gie <= `VIT_RST_GIE;
      psp <= `VIT_RST_PSP;
      hi_hold <= 8'h00;
      irq_req <= 1'b0;
      irq_vec <= '0;
    end
    else if (ce)
    begin
      state <= next_state;
      pend <= next_pend;
      gie <= next_gie;
      psp <= next_psp;
      hi_hold <= take ? {ret_flags, ret_pc[13:8]} : hi_hold;
      irq_req <= gie && (|act) && !take; // [RULE9]
      irq_vec <= top_idx; // [RULE9]
    end
  end

  // Stack write port: low PC byte first, then flags with upper PC bits.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stk_we <= 1'b0;
      stk_addr <= 8'h00;
      stk_wdata <= 8'h00;
    end
    else if (ce)
    begin
      stk_we <= push_step; // [RULE8]
      stk_addr <= psp;
      stk_wdata <= take ? ret_pc[7:0] : hi_hold; // [RULE8]
    end
  end

  // Software registers.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      en <= `VIT_RST_EN;
      gmask <= `VIT_RST_GMASK;
      gpol <= `VIT_RST_GPOL;
    end
    else if (wr_en)
    begin
      en <= hit_en ? pwdata[VIT_NSRC-1:0] : en; // [RULE1]
      gmask <= hit_gmask ? pwdata[GPIO_N-1:0] : gmask; // [RULE6]
      gpol <= hit_gpol ? pwdata[GPIO_N-1:0] : gpol; // [RULE7]
    end
  end

  // APB answer, registered.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else if (ce)
    begin
      pready <= acc;
      pslverr <= acc && !rd_hit;
      prdata <= (acc && !pwrite) ? rd_val : 32'h00000000;
    end
  end

  // Checks below run on the system clock and rest while reset is asserted.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  a_ack_clears_gie: assert property (take |=> !gie && !irq_req) // [RULE8]
    else $error("acknowledge left interrupts enabled");
  a_push_lo_byte: assert property (take |=> stk_we && stk_wdata == $past(ret_pc[7:0]) // [RULE8]
    && stk_addr == $past(psp))
    else $error("first stack byte wrong");
  a_push_hi_byte: assert property (take ##1 ce |=> stk_we // [RULE8]
    && stk_wdata == {$past(ret_flags, 2), $past(ret_pc[13:8], 2)}
    && psp == 8'($past(psp, 2) + 8'h02))
    else $error("second stack byte or pointer wrong");
  a_reti_restore: assert property (reti_take |=> gie && psp == 8'($past(psp) - 8'h02)) // [RULE8]
    else $error("return did not re-enable or pop");
  a_vec_priority: assert property (ce && gie && (|act) && !take |=> // [RULE9]
    irq_req && irq_vec == $past(top_idx) && $past(act[top_idx]))
    else $error("vector not the highest pending");
  a_pend_holds: assert property (pend[0] && !(take && irq_vec == 3'h0) |=> pend[0]) // [RULE9]
    else $error("pending request lost before taken");
  a_ack_clears_pend: assert property (take && !src_evt[irq_vec] |=> !pend[$past(irq_vec)]) // [RULE9]
    else $error("taken vector still pending");
  a_ep_done_sets: assert property (ce && ep0_done && en[`VIT_SRC_EP0] |=> pend[`VIT_SRC_EP0]) // [RULE5]
    else $error("endpoint completion not latched");
  a_timer_read: assert property (psel && penable && pready && !pwrite && hit_timer // [RULE4]
    && $past(ce) |-> prdata[CNT_W-1:0] == $past(count))
    else $error("timer read value wrong");
  a_masked_quiet: assert property (ce && !en[`VIT_SRC_FAST] && !pend[`VIT_SRC_FAST] // [RULE3]
    |=> !pend[`VIT_SRC_FAST])
    else $error("disabled tap became pending");
  // The push lasts two strobes, and a core with interrupts off sees no request.
  a_push_two_bytes: assert property (ce && state == VIT_PUSH_HI |=> !stk_we) // [RULE8]
    else $error("stack strobe longer than two bytes");
  a_push_hi_addr: assert property (take ##1 ce |=> // [RULE8]
    stk_addr == 8'($past(psp, 2) + 8'h01))
    else $error("second stack byte at wrong address");
  a_gie_gates_req: assert property (ce && !gie |=> !irq_req) // [RULE8]
    else $error("request offered while interrupts disabled");

  // Main scenarios: acknowledge, return and two sources waiting at once.
  c_take: cover property (take);
  c_reti: cover property (reti_take);
  c_two_pending: cover property (ce && act[0] && act[6] && gie);
endmodule

// ### logic/vit_defines.svh
// Offsets, field positions, reset values and timing figures of the interrupt controller.
`ifndef VIT_DEFINES_SVH
`define VIT_DEFINES_SVH

// Register byte offsets on the APB.
`define VIT_ADDR_EN 12'h000
`define VIT_ADDR_PEND 12'h004
`define VIT_ADDR_TIMER 12'h008
`define VIT_ADDR_GMASK 12'h00C
`define VIT_ADDR_GPOL 12'h010
`define VIT_ADDR_PSP 12'h014
`define VIT_ADDR_STAT 12'h018

// Field positions.
`define VIT_EN_GIE_BIT 8
`define VIT_SRC_BUSRST 0
`define VIT_SRC_FAST 1
`define VIT_SRC_SLOW 2
`define VIT_SRC_EP0 3
`define VIT_SRC_EP1 4
`define VIT_SRC_WAKE 5
`define VIT_SRC_GPIO 6

// Reset values.
`define VIT_RST_EN 7'h00
`define VIT_RST_GIE 1'b0
`define VIT_RST_GMASK 10'h000
`define VIT_RST_GPOL 10'h000
`define VIT_RST_PSP 8'h00

// Timing: clock period and timer tick in ns, tap periods in microseconds.
`define VIT_CLK_NS 10
`define VIT_TICK_NS 1000
`define VIT_FAST_US 128
`define VIT_SLOW_US 1024

`endif

// ### logic/vit_pkg.sv
// Types shared by the interrupt controller modules.
package vit_pkg;
  localparam int VIT_NSRC = 7;
  typedef logic [VIT_NSRC-1:0] vit_src_t;
  typedef logic [2:0] vit_vec_t;
  typedef enum {VIT_IDLE, VIT_PUSH_LO, VIT_PUSH_HI} vit_state_e;
endpackage

// ### logic/vit_timer.sv
// Free-running microsecond counter with two periodic taps.
module vit_timer
  import vit_pkg::*;
#(
  parameter int CNT_W = 12,
  parameter int TICK_CYC = 100,
  parameter int FAST_US = 128,
  parameter int SLOW_US = 1024
)
(
  input wire logic core_clk, // System clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable, freezes all state when low.
  output logic [CNT_W-1:0] count, // Current count, one step per microsecond.
  output logic tap_fast, // One-cycle pulse every FAST_US microseconds.
  output logic tap_slow // One-cycle pulse every SLOW_US microseconds.
);
  localparam int PW = $clog2(TICK_CYC);
  localparam int FB = $clog2(FAST_US);
  localparam int SB = $clog2(SLOW_US);

  logic [PW-1:0] presc;
  logic tick;

  // The prescaler turns the system clock into a one-microsecond tick.
  assign tick = ce && (presc == PW'(TICK_CYC - 1));

  // Counter wraps by itself; taps fire as the low bits roll over.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      presc <= '0;
      count <= '0;
      tap_fast <= 1'b0;
      tap_slow <= 1'b0;
    end
    else if (ce)
    begin
      presc <= tick ? '0 : PW'(presc + 1'b1);
      count <= tick ? CNT_W'(count + 1'b1) : count; // [RULE2]
      tap_fast <= tick && (&count[FB-1:0]); // [RULE3]
      tap_slow <= tick && (&count[SB-1:0]); // [RULE3]
    end
  end

  a_count_step: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE2]
    tick |=> count == CNT_W'($past(count) + 1'b1))
    else $error("timer did not step on tick");
  a_fast_tap: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE3]
    $rose(tap_fast) |-> count[FB-1:0] == '0)
    else $error("fast tap off its period");
  a_slow_tap: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE3]
    $rose(tap_slow) |-> count[SB-1:0] == '0 && tap_fast)
    else $error("slow tap off its period");
  c_slow_tap: cover property (@(posedge core_clk) disable iff (!nrst) tap_slow);
endmodule

// ### logic/vit_gpio_irq.sv
// Per-pin masked edge detector that forms the shared GPIO interrupt event.
module vit_gpio_irq
  import vit_pkg::*;
#(
  parameter int GPIO_N = 10
)
(
  input wire logic core_clk, // System clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable, freezes all state when low.
  input wire logic [GPIO_N-1:0] gpio_in, // Pin levels, synchronous to the clock.
  input wire logic [GPIO_N-1:0] mask, // One enables a pin.
  input wire logic [GPIO_N-1:0] pol, // One selects rising, zero falling edge.
  output logic evt // One-cycle pulse when an enabled pin sees its edge.
);
  logic [GPIO_N-1:0] prev;
  logic [GPIO_N-1:0] hit;

  // Each pin compares with its last level in the chosen direction.
  for (genvar i = 0; i < GPIO_N; i++)
  begin : g_pin
    assign hit[i] = mask[i] && (pol[i] ? (gpio_in[i] && !prev[i]) // [RULE6] [RULE7]
                                       : (!gpio_in[i] && prev[i])); // [RULE7]
  end

  // Last levels and the combined event.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prev <= '0;
      evt <= 1'b0;
    end
    else if (ce)
    begin
      prev <= gpio_in;
      evt <= |hit; // [RULE6]
    end
  end

  a_gpio_masked: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE6]
    $past(ce) && evt |-> |($past(mask) & ($past(gpio_in) ^ $past(prev))))
    else $error("gpio event without an enabled pin change");
  c_gpio_evt: cover property (@(posedge core_clk) disable iff (!nrst) evt);
endmodule

// ### dv/vit_core_model.sv
// Behavioural core that takes offered vectors, records stack bytes and returns.
module vit_core_model
  import vit_pkg::*;
(
  input wire logic core_clk, // System clock.
  input wire logic nrst, // Reset, active low.
  input wire logic irq_req, // Request from the controller.
  input wire vit_vec_t irq_vec, // Offered vector.
  input wire logic stk_we, // Stack write strobe.
  input wire logic [7:0] stk_addr, // Stack byte address.
  input wire logic [7:0] stk_wdata, // Stack byte data.
  input wire logic [3:0] ack_dly, // Cycles before a vector is taken.
  output logic irq_ack, // Takes the vector.
  output logic reti, // Return from interrupt.
  output logic [13:0] ret_pc, // Return address.
  output logic [1:0] ret_flags // Carry and zero.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:255];
  vit_vec_t vecs [0:63];
  time tacks [0:63];
  int nacks = 0;
  // A fixed return state keeps the pushed bytes predictable.
  assign ret_pc = 14'h02A5;
  assign ret_flags = 2'h2;
  initial
  begin
    irq_ack = 1'b0;
    reti = 1'b0;
  end
  // Stores every byte the controller pushes.
  always @(posedge core_clk)
    if (stk_we === 1'b1)
      mem[stk_addr] <= stk_wdata;
  // Waits, takes the vector, services it for a while and returns.
  always
  begin
    @(posedge core_clk);
    if (nrst === 1'b1 && irq_req === 1'b1)
    begin
      repeat (ack_dly) @(posedge core_clk);
      vecs[nacks] = irq_vec;
      tacks[nacks] = $time;
      irq_ack <= 1'b1;
      @(posedge core_clk);
      irq_ack <= 1'b0;
      nacks = nacks + 1;
      repeat (10) @(posedge core_clk);
      reti <= 1'b1;
      @(posedge core_clk);
      reti <= 1'b0;
      @(posedge core_clk);
    end
  end
endmodule

// ### dv/test_vit_top.sv
// Self-checking bench for the vectored interrupt controller.
`include "vit_defines.svh"
module test_vit_top
  import vit_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic usb_bus_reset = 1'b0;
  logic ep0_done = 1'b0;
  logic ep1_done = 1'b0;
  logic wake_evt = 1'b0;
  logic [9:0] gpio_in = 10'h000;
  logic [3:0] ack_dly = 4'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic err;
  logic irq_ack;
  logic reti;
  logic [13:0] ret_pc;
  logic [1:0] ret_flags;
  logic irq_req;
  vit_vec_t irq_vec;
  logic gie;
  logic stk_we;
  logic [7:0] stk_addr;
  logic [7:0] stk_wdata;
  logic [7:0] psp;
  int failures = 0;
  int total_checks = 0;
  int n0;

  // Clock at 100 MHz.
  always #5 core_clk = ~core_clk;

  // Controller under test and the core that services it.
  vit_top vit_top_i (.core_clk(core_clk), .nrst(nrst), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .usb_bus_reset(usb_bus_reset), .ep0_done(ep0_done),
    .ep1_done(ep1_done), .wake_evt(wake_evt), .gpio_in(gpio_in), .irq_ack(irq_ack),
    .reti(reti), .ret_pc(ret_pc), .ret_flags(ret_flags), .irq_req(irq_req),
    .irq_vec(irq_vec), .gie(gie), .stk_we(stk_we), .stk_addr(stk_addr),
    .stk_wdata(stk_wdata), .psp(psp));
  vit_core_model vit_core_model_i (.core_clk(core_clk), .nrst(nrst), .irq_req(irq_req),
    .irq_vec(irq_vec), .stk_we(stk_we), .stk_addr(stk_addr), .stk_wdata(stk_wdata),
    .ack_dly(ack_dly), .irq_ack(irq_ack), .reti(reti), .ret_pc(ret_pc),
    .ret_flags(ret_flags));

  // Compares one value and reports a mismatch.
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      failures++;
    end
  endtask

  // One APB transfer; read data and error are taken at the ready edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge core_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50)
      failures++;
  endtask

  // Waits until the core has taken n vectors, then lets the service end.
  task automatic wait_acks(input int n);
    int lim;
    lim = 0;
    while (vit_core_model_i.nacks < n && lim < 30000)
    begin
      lim++;
      @(posedge core_clk);
    end
    if (lim == 30000)
      failures++;
    repeat (16) @(posedge core_clk);
  endtask

  // Sets the pins and counts the vectors taken afterwards.
  task automatic gpio_set(input logic [9:0] v, input logic [31:0] exp);
    n0 = vit_core_model_i.nacks;
    @(posedge core_clk);
    gpio_in <= v;
    repeat (40) @(posedge core_clk);
    chk("gpio acks", exp, 32'(vit_core_model_i.nacks - n0));
  endtask

  // Reset values and an unmapped address.
  task automatic t_reset();
    apb(1'b0, `VIT_ADDR_EN, 32'h0);
    chk("en", 32'h0, rd);
    apb(1'b0, `VIT_ADDR_GMASK, 32'h0);
    chk("gmask", 32'h0, rd);
    apb(1'b0, `VIT_ADDR_GPOL, 32'h0);
    chk("gpol", 32'h0, rd);
    apb(1'b0, `VIT_ADDR_PSP, 32'h0);
    chk("psp", 32'h0, rd);
    apb(1'b0, 12'h01C, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
  endtask

  // Reads 1000 enabled cycles apart differ by ten; a stretch with the enable low adds nothing.
  task automatic t_timer();
    logic [11:0] t0;
    apb(1'b0, `VIT_ADDR_TIMER, 32'h0);
    t0 = rd[11:0];
    repeat (996) @(posedge core_clk);
    apb(1'b0, `VIT_ADDR_TIMER, 32'h0);
    chk("timer step", 32'hA, {20'h0, rd[11:0] - t0});
    t0 = rd[11:0];
    ce <= 1'b0;
    repeat (1000) @(posedge core_clk);
    ce <= 1'b1;
    repeat (996) @(posedge core_clk);
    apb(1'b0, `VIT_ADDR_TIMER, 32'h0);
    chk("timer frozen", 32'hA, {20'h0, rd[11:0] - t0});
  endtask

  // Simultaneous events latch, a disabled one is dropped, priority orders them.
  task automatic t_prio();
    apb(1'b1, `VIT_ADDR_EN, 32'h019);
    @(posedge core_clk);
    usb_bus_reset <= 1'b1;
    ep1_done <= 1'b1;
    wake_evt <= 1'b1;
    @(posedge core_clk);
    usb_bus_reset <= 1'b0;
    ep1_done <= 1'b0;
    wake_evt <= 1'b0;
    apb(1'b0, `VIT_ADDR_PEND, 32'h0);
    chk("pend", 32'h11, rd);
    n0 = vit_core_model_i.nacks;
    apb(1'b1, `VIT_ADDR_EN, 32'h119);
    wait_acks(n0 + 2);
    chk("first vec", 32'h0, {29'h0, vit_core_model_i.vecs[n0]});
    chk("second vec", 32'h4, {29'h0, vit_core_model_i.vecs[n0 + 1]});
  endtask

  // Endpoint request with a slow core: stack push, disable and return.
  task automatic t_stack();
    int n;
    n = 0;
    ack_dly <= 4'h5;
    apb(1'b1, `VIT_ADDR_PSP, 32'h10);
    @(posedge core_clk);
    ep0_done <= 1'b1;
    @(posedge core_clk);
    ep0_done <= 1'b0;
    while (stk_we !== 1'b1 && n < 100)
    begin
      n++;
      @(posedge core_clk);
    end
    if (n == 100)
      failures++;
    repeat (3) @(posedge core_clk);
    chk("gie in service", 32'h0, {31'h0, gie});
    chk("psp pushed", 32'h12, {24'h0, psp});
    repeat (15) @(posedge core_clk);
    chk("gie returned", 32'h1, {31'h0, gie});
    chk("psp returned", 32'h10, {24'h0, psp});
    chk("stack lo", 32'hA5, {24'h0, vit_core_model_i.mem[16]});
    chk("stack hi", 32'h82, {24'h0, vit_core_model_i.mem[17]});
    chk("ep vec", 32'h3, {29'h0, vit_core_model_i.vecs[vit_core_model_i.nacks - 1]});
  endtask

  // Pin mask and per-pin edge choice.
  task automatic t_gpio();
    apb(1'b1, `VIT_ADDR_GMASK, 32'h008);
    apb(1'b1, `VIT_ADDR_GPOL, 32'h008);
    apb(1'b1, `VIT_ADDR_EN, 32'h140);
    gpio_set(10'h020, 32'h0);
    gpio_set(10'h028, 32'h1);
    chk("gpio vec", 32'h6, {29'h0, vit_core_model_i.vecs[n0]});
    gpio_set(10'h020, 32'h0);
    apb(1'b1, `VIT_ADDR_GPOL, 32'h000);
    gpio_set(10'h028, 32'h0);
    gpio_set(10'h020, 32'h1);
    apb(1'b1, `VIT_ADDR_GMASK, 32'h000);
    gpio_set(10'h028, 32'h0);
    gpio_set(10'h020, 32'h0);
  endtask

  // The fast tap repeats every 128 us while enabled and stops when disabled.
  task automatic t_tap();
    n0 = vit_core_model_i.nacks;
    apb(1'b1, `VIT_ADDR_EN, 32'h102);
    wait_acks(n0 + 2);
    chk("tap vec", 32'h1, {29'h0, vit_core_model_i.vecs[n0]});
    chk("tap gap", 32'd12800,
      32'((vit_core_model_i.tacks[n0 + 1] - vit_core_model_i.tacks[n0]) / 10));
    apb(1'b1, `VIT_ADDR_EN, 32'h100);
    n0 = vit_core_model_i.nacks;
    repeat (13000) @(posedge core_clk);
    chk("tap off", 32'h0, 32'(vit_core_model_i.nacks - n0));
  endtask

  // Prints the verdict and ends the run.
  task automatic stop_test();
    if (failures == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Main sequence after 16 cycles of reset.
  initial
  begin
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_timer();
    t_prio();
    t_stack();
    t_gpio();
    t_tap();
    stop_test();
  end

  // Cuts a hang short well after the expected run of about 40000 cycles.
  initial
  begin
    #800us;
    failures++;
    stop_test();
  end
endmodule
